// *** core/rwi_map.svh ***
// Register offsets, field positions, reset values and bus answers of the read-path integrity block.
// Assumes inclusion by bare name from package and design files.
`ifndef RWI_MAP_SVH
`define RWI_MAP_SVH
`define RWI_OFF_CFG 8'h00
`define RWI_OFF_STAT 8'h04
`define RWI_OFF_CRC 8'h08
`define RWI_OFF_CLR 8'h0c
`define RWI_CFG_WRAP_BIT 4
`define RWI_CFG_MODE_BIT 3
`define RWI_CFG_LEN_LSB 0
`define RWI_STAT_DBL_BIT 4
`define RWI_STAT_SGL_BIT 3
`define RWI_CFG_WRAP_RST 1'b0
`define RWI_CFG_MODE_RST 1'b1
`define RWI_CRC_RST 32'h0000_0000
`define RWI_ADDR_RST 32'h0000_0000
`define RWI_RESP_OKAY 2'h0
`define RWI_RESP_SLVERR 2'h2
`define RWI_MASK_W8 6'h07
`define RWI_MASK_W16 6'h0f
`define RWI_MASK_W32 6'h1f
`define RWI_MASK_W64 6'h3f
`endif

// *** core/rwi_pkg.sv ***
// Types and shared decoders of the read-path integrity block.
// Assumes rwi_map.svh is on the include path.
`include "rwi_map.svh"
package rwi_pkg;
  typedef logic [31:0] rwi_word_t;
  typedef logic [7:0] rwi_aoff_t;
  typedef logic [127:0] rwi_unit_t;
  typedef logic [8:0] rwi_chk_t;
  typedef logic [1:0] rwi_gray_t;
  typedef enum logic [1:0] {
    rwi_wrap8 = 2'h0,
    rwi_wrap16 = 2'h1,
    rwi_wrap32 = 2'h2,
    rwi_wrap64 = 2'h3
  } rwi_wrap_t;
  typedef struct packed {
    logic wrap_en;
    logic mode;
    rwi_wrap_t len;
  } rwi_cfg_t;
  typedef struct packed {
    rwi_word_t addr;
  } rwi_gen_st_t;
  typedef struct packed {
    logic aw_got;
    rwi_aoff_t aw_addr;
    logic w_got;
    rwi_word_t w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    rwi_word_t r_data;
    logic [1:0] r_resp;
    rwi_cfg_t cfg;
    logic sgl;
    logic dbl;
    rwi_word_t crc;
    rwi_gray_t sg_m;
    rwi_gray_t sg_s;
    rwi_gray_t sg_p;
    rwi_gray_t dg_m;
    rwi_gray_t dg_s;
    rwi_gray_t dg_p;
  } rwi_axi_st_t;
  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic ce_m;
    logic ce_s;
    rwi_cfg_t cfg_m;
    rwi_cfg_t cfg_s;
    rwi_gray_t sgl_g;
    rwi_gray_t dbl_g;
  } rwi_lnk_st_t;

  // Offset bits that move inside the aligned group of each wrap length.
  function automatic logic [5:0] rwi_wrap_mask(input rwi_wrap_t len);
    case (len)
      rwi_wrap8: return `RWI_MASK_W8;
      rwi_wrap16: return `RWI_MASK_W16;
      rwi_wrap32: return `RWI_MASK_W32;
      default: return `RWI_MASK_W64;
    endcase
  endfunction : rwi_wrap_mask

  // Two-bit Gray step, so a counted event changes one bit at a time.
  function automatic rwi_gray_t rwi_gray_inc(input rwi_gray_t g);
    return {g[0], ~g[1]};
  endfunction : rwi_gray_inc
endpackage : rwi_pkg

// *** core/rwi_rd_if.sv ***
// Burst read control between the link-side logic and the address generator.
// Assumes all signals belong to the link clock domain.
`timescale 1ns/1ps
`default_nettype none
interface rwi_rd_if;
  import rwi_pkg::*;
  logic start;
  logic step;
  rwi_word_t start_addr;
  logic wrap_en;
  rwi_wrap_t wrap_len;
  rwi_word_t addr;
  modport ctl (output start, step, start_addr, wrap_en, wrap_len, input addr);
  modport gen (input start, step, start_addr, wrap_en, wrap_len, output addr);
endinterface : rwi_rd_if
`default_nettype wire

// *** core/rwi_ecc_chk.sv ***
// Combinational SECDED check of one 16-byte data unit against its nine check bits.
// Assumes check bits 7:0 are the Hamming code and bit 8 the parity over the whole codeword.
`timescale 1ns/1ps
`default_nettype none
module rwi_ecc_chk #(
  parameter int DATA_W = 128,
  parameter int CHK_W = 9
) (
  input wire logic [DATA_W-1:0] unit_data,
  input wire logic [CHK_W-1:0] unit_check,
  input wire logic sec_ded_en,
  output logic err_single,
  output logic err_double
);
  import rwi_pkg::*;

  // Data bits sit at the Hamming positions that are not powers of two.
  function automatic logic [CHK_W-2:0] syn_of(input logic [DATA_W-1:0] d);
    logic [CHK_W-2:0] s;
    int p;
    s = '0;
    p = 2;
    for (int i = 0; i < DATA_W; i++) begin
      p++;
      if ((p & (p - 1)) == 0) begin
        p++;
      end
      if (d[i]) begin
        s ^= p[CHK_W-2:0];
      end
    end
    return s;
  endfunction : syn_of

  logic [CHK_W-2:0] syn;
  logic par_bad;

  always_comb begin
    syn = syn_of(unit_data) ^ unit_check[CHK_W-2:0];
    par_bad = ^{unit_data, unit_check};
    err_single = 1'b0;
    err_double = 1'b0;
    if (sec_ded_en) begin
      err_single = par_bad;
      err_double = ~par_bad & (syn != '0);
    end else begin
      err_single = par_bad | (syn != '0);
    end
  end
endmodule : rwi_ecc_chk
`default_nettype wire

// *** core/rwi_addr_gen.sv ***
// Burst address generator: loads a start address, then steps sequentially or wraps in an aligned group.
// Assumes start has priority over step and both are already gated by the clock enable.
`timescale 1ns/1ps
`default_nettype none
module rwi_addr_gen (
  input wire logic link_clk,
  input wire logic lnk_rst_n,
  rwi_rd_if.gen rd
);
  import rwi_pkg::*;
  rwi_gen_st_t gen_ff;
  rwi_gen_st_t nxt_gen;
  logic [5:0] msk;

  always_comb begin
    msk = rwi_wrap_mask(rd.wrap_len);
    nxt_gen = gen_ff;
    if (!lnk_rst_n) begin
      nxt_gen.addr = `RWI_ADDR_RST;
    end else if (rd.start) begin
      nxt_gen.addr = rd.start_addr;
    end else if (rd.step) begin
      if (rd.wrap_en) begin
        nxt_gen.addr[5:0] = (gen_ff.addr[5:0] & ~msk) | (6'(gen_ff.addr[5:0] + 6'h01) & msk);
      end else begin
        nxt_gen.addr = gen_ff.addr + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    gen_ff <= nxt_gen;
  end

  assign rd.addr = gen_ff.addr;

  default clocking gen_cb @(posedge link_clk); endclocking
  default disable iff (!lnk_rst_n);

  seq_step_a: assert property (
    rd.step && !rd.start && !rd.wrap_en |=> rd.addr == 32'($past(rd.addr) + 32'h0000_0001))
    else $error("sequential read did not advance by one");
  wrap_eight_a: assert property (
    rd.step && !rd.start && rd.wrap_en && rd.wrap_len == rwi_wrap8
    |=> rd.addr[31:3] == $past(rd.addr[31:3]) && rd.addr[2:0] == 3'($past(rd.addr[2:0]) + 3'h1))
    else $error("8-byte wrap left its group");
  wrap_sixteen_a: assert property (
    rd.step && !rd.start && rd.wrap_en && rd.wrap_len == rwi_wrap16
    |=> rd.addr[31:4] == $past(rd.addr[31:4]) && rd.addr[3:0] == 4'($past(rd.addr[3:0]) + 4'h1))
    else $error("16-byte wrap left its group");
  wrap_thirtytwo_a: assert property (
    rd.step && !rd.start && rd.wrap_en && rd.wrap_len == rwi_wrap32
    |=> rd.addr[31:5] == $past(rd.addr[31:5]) && rd.addr[4:0] == 5'($past(rd.addr[4:0]) + 5'h01))
    else $error("32-byte wrap left its group");
  wrap_sixtyfour_a: assert property (
    rd.step && !rd.start && rd.wrap_en && rd.wrap_len == rwi_wrap64
    |=> rd.addr[31:6] == $past(rd.addr[31:6]) && rd.addr[5:0] == 6'($past(rd.addr[5:0]) + 6'h01))
    else $error("64-byte wrap left its group");
  wrap_roll_c: cover property (
    rd.step && !rd.start && rd.wrap_en && rd.wrap_len == rwi_wrap64 && rd.addr[5:0] == `RWI_MASK_W64);
endmodule : rwi_addr_gen
`default_nettype wire

// *** core/rwi_top.sv ***
// Read-path integrity block: AXI4-Lite register slave on aclk, burst address
// sequencing and per-unit ECC checking on the link clock.
// Assumes the array presents the 16-byte unit holding link_addr, with its
// check bits, in every link cycle in which link_byte_rd is high.
`timescale 1ns/1ps
`default_nettype none
`include "rwi_map.svh"

// How it works
// - Wrap off: addresses simply keep incrementing.
// - 8-byte wrap cycles low three bits.
// - 16-byte wrap cycles low four bits.
// - 32-byte wrap cycles low five bits.
// - 64-byte wrap cycles low six bits.
// - Read-only 32-bit checksum result, reset zero.
// - ECC checked per 128-bit data unit.
// - Every array byte read updates error status.
// - Double error sets status bit four.
// - Double flag sticks until clear transaction.
// - Single error sets sticky status bit three.
// - Reserved status bits read zero, written default.
// - Error mode enables double-error detection.
// - Wrap enable picks wrapped or sequential reads.
// - Wrap length code picks 8/16/32/64 bytes.
module rwi_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire rwi_pkg::rwi_aoff_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire rwi_pkg::rwi_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire rwi_pkg::rwi_aoff_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output var rwi_pkg::rwi_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crc_load,
  input wire rwi_pkg::rwi_word_t crc_value,
  input wire logic link_clk,
  input wire logic link_start,
  input wire rwi_pkg::rwi_word_t link_start_addr,
  input wire logic link_byte_rd,
  input wire rwi_pkg::rwi_unit_t unit_data,
  input wire rwi_pkg::rwi_chk_t unit_check,
  output var rwi_pkg::rwi_word_t link_addr
);
  import rwi_pkg::*;

  rwi_axi_st_t ax_ff;
  rwi_axi_st_t nxt_ax;
  rwi_lnk_st_t lk_ff;
  rwi_lnk_st_t nxt_lk;

  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic wr_go;
  rwi_aoff_t wr_addr;
  rwi_word_t wr_data;
  logic [3:0] wr_strb;
  logic clr;
  logic sg_evt;
  logic dg_evt;
  rwi_word_t rd_word;
  logic [1:0] rd_resp;
  logic err_sgl;
  logic err_dbl;

  // ---------------- Register slave, aclk domain ----------------

  assign s_axi_awready = ce & ~ax_ff.aw_got & ~ax_ff.b_valid;
  assign s_axi_wready = ce & ~ax_ff.w_got & ~ax_ff.b_valid;
  assign s_axi_arready = ce & ~ax_ff.r_valid;
  assign s_axi_bvalid = ce & ax_ff.b_valid;
  assign s_axi_rvalid = ce & ax_ff.r_valid;
  assign s_axi_bresp = ax_ff.b_resp;
  assign s_axi_rresp = ax_ff.r_resp;
  assign s_axi_rdata = ax_ff.r_data;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign b_hs = s_axi_bvalid & s_axi_bready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign r_hs = s_axi_rvalid & s_axi_rready;

  // Address and data may arrive in either order; the write acts in the cycle in which the later of the two is taken.
  assign wr_addr = ax_ff.aw_got ? ax_ff.aw_addr : s_axi_awaddr;
  assign wr_data = ax_ff.w_got ? ax_ff.w_data : s_axi_wdata;
  assign wr_strb = ax_ff.w_got ? ax_ff.w_strb : s_axi_wstrb;
  assign wr_go = (ax_ff.aw_got | aw_hs) & (ax_ff.w_got | w_hs);
  assign clr = wr_go & (wr_addr == `RWI_OFF_CLR);

  // Any change of the synchronised Gray count is at least one error event.
  assign sg_evt = ax_ff.sg_s != ax_ff.sg_p;
  assign dg_evt = ax_ff.dg_s != ax_ff.dg_p;

  always_comb begin
    rd_word = '0;
    rd_resp = `RWI_RESP_OKAY;
    case (s_axi_araddr)
      `RWI_OFF_CFG: begin
        rd_word[`RWI_CFG_WRAP_BIT] = ax_ff.cfg.wrap_en;
        rd_word[`RWI_CFG_MODE_BIT] = ax_ff.cfg.mode;
        rd_word[`RWI_CFG_LEN_LSB +: $bits(rwi_wrap_t)] = ax_ff.cfg.len;
      end
      `RWI_OFF_STAT: begin
        rd_word[`RWI_STAT_DBL_BIT] = ax_ff.dbl;
        rd_word[`RWI_STAT_SGL_BIT] = ax_ff.sgl;
      end
      `RWI_OFF_CRC: begin
        rd_word = ax_ff.crc;
      end
      `RWI_OFF_CLR: begin
        rd_word = '0;
      end
      default: begin
        rd_resp = `RWI_RESP_SLVERR;
      end
    endcase
  end

  always_comb begin
    nxt_ax = ax_ff;
    if (!aresetn) begin
      nxt_ax = '0;
      nxt_ax.cfg.wrap_en = `RWI_CFG_WRAP_RST;
      nxt_ax.cfg.mode = `RWI_CFG_MODE_RST;
      nxt_ax.cfg.len = rwi_wrap8;
      nxt_ax.crc = `RWI_CRC_RST;
    end else if (ce) begin
      if (aw_hs) begin
        nxt_ax.aw_got = 1'b1;
        nxt_ax.aw_addr = s_axi_awaddr;
      end
      if (w_hs) begin
        nxt_ax.w_got = 1'b1;
        nxt_ax.w_data = s_axi_wdata;
        nxt_ax.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
        nxt_ax.aw_got = 1'b0;
        nxt_ax.w_got = 1'b0;
        nxt_ax.b_valid = 1'b1;
        nxt_ax.b_resp = `RWI_RESP_SLVERR;
        case (wr_addr)
          `RWI_OFF_CFG: begin
            nxt_ax.b_resp = `RWI_RESP_OKAY;
            if (wr_strb[0]) begin
              nxt_ax.cfg.wrap_en = wr_data[`RWI_CFG_WRAP_BIT];
              nxt_ax.cfg.mode = wr_data[`RWI_CFG_MODE_BIT];
              nxt_ax.cfg.len = rwi_wrap_t'(wr_data[`RWI_CFG_LEN_LSB +: $bits(rwi_wrap_t)]);
            end
          end
          `RWI_OFF_CLR: begin
            nxt_ax.b_resp = `RWI_RESP_OKAY;
          end
          default: begin
            nxt_ax.b_resp = `RWI_RESP_SLVERR;
          end
        endcase
      end else if (b_hs) begin
        nxt_ax.b_valid = 1'b0;
      end
      if (ar_hs) begin
        nxt_ax.r_valid = 1'b1;
        nxt_ax.r_data = rd_word;
        nxt_ax.r_resp = rd_resp;
      end else if (r_hs) begin
        nxt_ax.r_valid = 1'b0;
      end
      if (crc_load) begin
        nxt_ax.crc = crc_value;
      end
      nxt_ax.sg_m = lk_ff.sgl_g;
      nxt_ax.sg_s = ax_ff.sg_m;
      nxt_ax.sg_p = ax_ff.sg_s;
      nxt_ax.dg_m = lk_ff.dbl_g;
      nxt_ax.dg_s = ax_ff.dg_m;
      nxt_ax.dg_p = ax_ff.dg_s;
      // A new event wins over a clear in the same cycle.
      nxt_ax.sgl = (ax_ff.sgl & ~clr) | sg_evt;
      nxt_ax.dbl = (ax_ff.dbl & ~clr) | (dg_evt & ax_ff.cfg.mode);
    end
  end

  always_ff @(posedge aclk) begin
    ax_ff <= nxt_ax;
  end

  // ---------------- Link domain ----------------

  rwi_rd_if rd ();

  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.rst_m = aresetn;
    nxt_lk.rst_s = lk_ff.rst_m;
    nxt_lk.ce_m = ce;
    nxt_lk.ce_s = lk_ff.ce_m;
    if (!lk_ff.rst_s) begin
      nxt_lk.cfg_m = '0;
      nxt_lk.cfg_s = '0;
      nxt_lk.sgl_g = '0;
      nxt_lk.dbl_g = '0;
    end else if (lk_ff.ce_s) begin
      // The configuration is a quasi-static level; change it only between bursts.
      nxt_lk.cfg_m = ax_ff.cfg;
      nxt_lk.cfg_s = lk_ff.cfg_m;
      if (rd.step && err_sgl) begin
        nxt_lk.sgl_g = rwi_gray_inc(lk_ff.sgl_g);
      end
      if (rd.step && err_dbl) begin
        nxt_lk.dbl_g = rwi_gray_inc(lk_ff.dbl_g);
      end
    end
  end

  always_ff @(posedge link_clk) begin
    lk_ff <= nxt_lk;
  end

  assign rd.start = link_start & lk_ff.ce_s & lk_ff.rst_s;
  assign rd.step = link_byte_rd & lk_ff.ce_s & lk_ff.rst_s;
  assign rd.start_addr = link_start_addr;
  assign rd.wrap_en = lk_ff.cfg_s.wrap_en;
  assign rd.wrap_len = lk_ff.cfg_s.len;
  assign link_addr = rd.addr;

  rwi_addr_gen u_gen (
    .link_clk(link_clk),
    .lnk_rst_n(lk_ff.rst_s),
    .rd(rd.gen)
  );

  rwi_ecc_chk #(
    .DATA_W($bits(rwi_unit_t)),
    .CHK_W($bits(rwi_chk_t))
  ) u_ecc (
    .unit_data(unit_data),
    .unit_check(unit_check),
    .sec_ded_en(lk_ff.cfg_s.mode),
    .err_single(err_sgl),
    .err_double(err_dbl)
  );

  // ---------------- Checks ----------------

  default clocking top_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  crc_hold_a: assert property (
    ce && !crc_load |=> $stable(ax_ff.crc))
    else $error("checksum result changed without a load");
  crc_load_a: assert property (
    ce && crc_load |=> ax_ff.crc == $past(crc_value))
    else $error("checksum result missed its load");
  reset_zero_a: assert property (
    disable iff (1'b0) !aresetn |=> ax_ff.crc == `RWI_CRC_RST && !ax_ff.sgl && !ax_ff.dbl)
    else $error("reset left a flag or checksum set");
  dbl_set_a: assert property (
    ce && dg_evt && ax_ff.cfg.mode |=> ax_ff.dbl ##1 ax_ff.dbl || !$past(ce) || $past(clr))
    else $error("double error did not set its flag");
  dbl_sticky_a: assert property (
    ax_ff.dbl && !(ce && clr) |=> ax_ff.dbl)
    else $error("double flag dropped without clear");
  sgl_sticky_a: assert property (
    ax_ff.sgl && !(ce && clr) |=> ax_ff.sgl)
    else $error("single flag dropped without clear");
  clr_both_a: assert property (
    ce && clr && !sg_evt && !dg_evt |=> !ax_ff.sgl && !ax_ff.dbl)
    else $error("clear left a flag set");
  set_wins_a: assert property (
    ce && clr && sg_evt |=> ax_ff.sgl)
    else $error("event lost to a clear");
  mode_gate_a: assert property (
    $rose(ax_ff.dbl) |-> $past(ax_ff.cfg.mode))
    else $error("double flag set in correction-only mode");
  stat_rsv_a: assert property (
    ar_hs && s_axi_araddr == `RWI_OFF_STAT
    |=> s_axi_rdata[31:5] == '0 && s_axi_rdata[2:0] == '0 && s_axi_rdata[4] == $past(ax_ff.dbl))
    else $error("status read shows reserved bits");
  evt_link_a: assert property (
    @(posedge link_clk) disable iff (!lk_ff.rst_s)
    rd.step && err_dbl |=> lk_ff.dbl_g != $past(lk_ff.dbl_g))
    else $error("double error on a read was not counted");
  ecc_clean_a: assert property (
    @(posedge link_clk) disable iff (!lk_ff.rst_s)
    rd.step && unit_data == '0 && unit_check == '0 |=> $stable(lk_ff.sgl_g) && $stable(lk_ff.dbl_g))
    else $error("clean data unit reported an error");

  // Bus answers stand until taken, and no new request of the same kind is accepted meanwhile.
  b_hold_a: assert property (
    ax_ff.b_valid && !b_hs |=> ax_ff.b_valid && $stable(ax_ff.b_resp))
    else $error("write response dropped before it was taken");
  r_hold_a: assert property (
    ax_ff.r_valid && !r_hs |=> ax_ff.r_valid && $stable(ax_ff.r_data) && $stable(ax_ff.r_resp))
    else $error("read answer changed before it was taken");
  b_answer_a: assert property (
    ce && wr_go |=> ax_ff.b_valid)
    else $error("write got no response");
  r_answer_a: assert property (
    ce && ar_hs |=> ax_ff.r_valid)
    else $error("read got no answer");
  ar_block_a: assert property (
    ax_ff.r_valid |-> !s_axi_arready)
    else $error("read address taken while a read was open");
  aw_block_a: assert property (
    ax_ff.b_valid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response was open");
  cfg_write_a: assert property (
    ce && wr_go && wr_addr == `RWI_OFF_CFG && wr_strb[0]
    |=> ax_ff.cfg.wrap_en == $past(wr_data[`RWI_CFG_WRAP_BIT]))
    else $error("configuration write did not land");
  ro_write_a: assert property (
    ce && wr_go && wr_addr == `RWI_OFF_STAT |=> ax_ff.b_resp == `RWI_RESP_SLVERR)
    else $error("status write was accepted");
  sgl_set_a: assert property (
    ce && sg_evt |=> ax_ff.sgl)
    else $error("single error did not set its flag");
  crc_ro_a: assert property (
    ce && wr_go && wr_addr == `RWI_OFF_CRC && !crc_load |=> $stable(ax_ff.crc))
    else $error("checksum result changed by a bus write");
  cfg_sync_a: assert property (
    @(posedge link_clk) disable iff (!lk_ff.rst_s)
    lk_ff.ce_s |=> lk_ff.cfg_s == $past(lk_ff.cfg_m))
    else $error("configuration did not reach the link side");

  dbl_rise_c: cover property ($rose(ax_ff.dbl));
  clr_flags_c: cover property (ce && clr && ax_ff.sgl && ax_ff.dbl);
  unmapped_c: cover property (ar_hs && rd_resp == `RWI_RESP_SLVERR);
  wrap_cfg_c: cover property (ce && wr_go && wr_addr == `RWI_OFF_CFG && wr_data[`RWI_CFG_WRAP_BIT]);
endmodule : rwi_top
`default_nettype wire

// *** test/rwi_host_model.sv ***
// Host-side model of the link: frames burst reads and presents array units with chosen errors.
// Assumes a free-running 15 ns clock input that it gates into the link clock between frames.
`timescale 1ns/1ps
`default_nettype none
module rwi_host_model
  import rwi_pkg::*;
(
  input wire logic clk_free,
  output logic link_clk,
  output logic link_start,
  output rwi_pkg::rwi_word_t link_start_addr,
  output logic link_byte_rd,
  output rwi_pkg::rwi_unit_t unit_data,
  output rwi_pkg::rwi_chk_t unit_check,
  input wire rwi_pkg::rwi_word_t link_addr
);
  logic run;
  rwi_word_t seen[$];
  assign link_clk = clk_free & run;
  initial begin
    run = 1'b1;
    link_start = 1'b0;
    link_start_addr = '0;
    link_byte_rd = 1'b0;
    unit_data = '1;
    unit_check = '1;
  end
  // Error kind 1 flips one data bit with parity off, kind 2 flips two data bits with parity kept.
  task automatic burst(input rwi_word_t a, input int n, input logic [1:0] err);
    seen.delete();
    @(negedge clk_free) run = 1'b1;
    repeat (4) @(posedge link_clk);
    link_start <= 1'b1;
    link_start_addr <= a;
    @(posedge link_clk);
    link_start <= 1'b0;
    link_start_addr <= ~a;
    for (int i = 0; i < n; i++) begin
      link_byte_rd <= 1'b1;
      unit_data <= (i == 0 && err == 2'd1) ? 128'h1 : (i == 0 && err == 2'd2) ? 128'h3 : 128'h0;
      unit_check <= '0;
      @(posedge link_clk);
      seen.push_back(link_addr);
    end
    link_byte_rd <= 1'b0;
    unit_data <= '1;
    unit_check <= '1;
    repeat (3) @(posedge link_clk);
    @(negedge clk_free) run = 1'b0;
  endtask : burst
endmodule : rwi_host_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench of the read-path integrity block over AXI4-Lite and the link.
// Assumes rwi_map.svh on the include path and the host model in rwi_host_model.sv.
`timescale 1ns/1ps
`default_nettype none
`include "rwi_map.svh"
module testbench;
  import rwi_pkg::*;
  logic aclk, aresetn, ce, lclk_free, link_clk, link_start, link_byte_rd, crc_load;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rwi_aoff_t s_axi_awaddr, s_axi_araddr;
  rwi_word_t s_axi_wdata, s_axi_rdata, crc_value, link_start_addr, link_addr;
  rwi_unit_t unit_data;
  rwi_chk_t unit_check;
  int n_fail, checks_done, cyc_cnt;

  rwi_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crc_load, .crc_value, .link_clk, .link_start, .link_start_addr, .link_byte_rd,
    .unit_data, .unit_check, .link_addr);
  rwi_host_model host (.clk_free(lclk_free), .link_clk, .link_start, .link_start_addr,
    .link_byte_rd, .unit_data, .unit_check, .link_addr);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    lclk_free = 1'b0;
    #3.1;
    forever #7.5 lclk_free = ~lclk_free;
  end
  always @(posedge aclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk_word(input rwi_word_t got, input rwi_word_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp
  task automatic axi_wr(input rwi_aoff_t a, input rwi_word_t d, input logic [1:0] exp_r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk_resp(s_axi_bresp, exp_r);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input rwi_aoff_t a, input rwi_word_t mask, input rwi_word_t exp_d,
      input logic [1:0] exp_r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk_word(s_axi_rdata & mask, exp_d);
    chk_resp(s_axi_rresp, exp_r);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // A zero mask means sequential stepping across all address bits.
  task automatic burst_chk(input rwi_word_t a, input int n, input rwi_word_t mask);
    host.burst(a, n, 2'd0);
    chk_word(32'(host.seen.size()), 32'(n));
    foreach (host.seen[i])
      chk_word(host.seen[i], (mask == 0) ? a + 32'(i) : (a & ~mask) | ((a + 32'(i)) & mask));
  endtask : burst_chk
  task automatic err_burst(input logic [1:0] err, input rwi_word_t mask, input rwi_word_t exp);
    host.burst(32'h0000_0100, 4, err);
    repeat (8) @(posedge aclk);
    axi_rd(`RWI_OFF_STAT, mask, exp, `RWI_RESP_OKAY);
  endtask : err_burst

  task automatic t_reset();
    axi_rd(`RWI_OFF_CFG, '1, 32'h08, `RWI_RESP_OKAY);
    axi_rd(`RWI_OFF_STAT, '1, 32'h0, `RWI_RESP_OKAY);
    axi_rd(`RWI_OFF_CRC, '1, `RWI_CRC_RST, `RWI_RESP_OKAY);
    axi_rd(8'h10, '1, 32'h0, `RWI_RESP_SLVERR);
    axi_wr(8'h12, 32'h1, `RWI_RESP_SLVERR);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_crc();
    @(posedge aclk);
    crc_value <= 32'hc0de_5a11;
    crc_load <= 1'b1;
    @(posedge aclk);
    crc_load <= 1'b0;
    axi_rd(`RWI_OFF_CRC, '1, 32'hc0de_5a11, `RWI_RESP_OKAY);
    axi_wr(`RWI_OFF_CRC, 32'h0, `RWI_RESP_SLVERR);
    axi_rd(`RWI_OFF_CRC, '1, 32'hc0de_5a11, `RWI_RESP_OKAY);
    $display("test checksum finished");
  endtask : t_crc
  task automatic t_seq();
    axi_wr(`RWI_OFF_CFG, 32'h08, `RWI_RESP_OKAY);
    burst_chk(32'h00ff_fffd, 6, 32'h0);
    $display("test sequential finished");
  endtask : t_seq
  task automatic t_wrap();
    rwi_word_t offs[4];
    offs = '{32'h07, 32'h02, 32'h0a, 32'h2e};
    for (int k = 0; k < 4; k++) begin
      axi_wr(`RWI_OFF_CFG, 32'h18 | 32'(k), `RWI_RESP_OKAY);
      axi_rd(`RWI_OFF_CFG, '1, 32'h18 | 32'(k), `RWI_RESP_OKAY);
      burst_chk(32'h5a5a_5a40 | offs[k], (8 << k) + 2, (32'h8 << k) - 1);
    end
    $display("test wrap finished");
  endtask : t_wrap
  task automatic t_ecc();
    axi_wr(`RWI_OFF_CFG, 32'h08, `RWI_RESP_OKAY);
    axi_wr(`RWI_OFF_CLR, 32'h0, `RWI_RESP_OKAY);
    err_burst(2'd1, '1, 32'h08);
    err_burst(2'd0, '1, 32'h08);
    err_burst(2'd2, 32'hf7, 32'h10);
    err_burst(2'd0, 32'hf7, 32'h10);
    axi_wr(`RWI_OFF_STAT, 32'h0, `RWI_RESP_SLVERR);
    axi_wr(`RWI_OFF_CLR, 32'h0, `RWI_RESP_OKAY);
    axi_rd(`RWI_OFF_STAT, '1, 32'h0, `RWI_RESP_OKAY);
    axi_wr(`RWI_OFF_CFG, 32'h00, `RWI_RESP_OKAY);
    err_burst(2'd2, '1, 32'h08);
    $display("test error status finished");
  endtask : t_ecc

  initial begin
    {ce, aresetn, crc_load, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, crc_value} = '0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_crc();
    t_seq();
    t_wrap();
    t_ecc();
    conclude();
  end
endmodule : testbench
`default_nettype wire
